// File: design/odf_top.sv
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "odf_consts.svh"
module odf_top import odf_pkg::*; #(
	parameter int CH = 8,
	parameter int TICK_CYC_1 = `ODF_TICK1_CYC,
	parameter int TICK_CYC_2 = `ODF_TICK2_CYC,
	parameter int TICK_CYC_3 = `ODF_TICK3_CYC
) (
	input wire logic clock,
	input wire logic nrst,
	// field side, comparator decisions
	input wire logic [CH-1:0] field_inputs,
	input wire logic trip_point_select,
	input wire logic filter_select_lo,
	input wire logic filter_select_hi,
	input wire logic over_temp,
	input wire logic supply_low,
	// logic side
	output logic [CH-1:0] channel_logic_outputs,
	output logic fault_n,
	output logic low_supply_alarm_n,
	output logic industrial_trip,
	output logic current_full,
	output logic irq,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	// ----------------------------------------------------------------
	// registers and setting selection
	// ----------------------------------------------------------------
	logic [31:0] ctrl; // override enable and setting
	logic [`ODF_STS_W-1:0] status; // sticky events
	logic [`ODF_STS_W-1:0] mask; // interrupt enables
	wire logic [1:0] pin_sel; // setting from the select pins
	wire logic [1:0] sel_raw; // effective setting bits
	odf_tick_if tk ();

	// high select pin is the upper bit
	assign pin_sel = {filter_select_hi, filter_select_lo};
	// software may override the pins, e.g. while commissioning
	assign sel_raw = ctrl[`ODF_CTRL_OVR_BIT] ? ctrl[`ODF_CTRL_SEL_LSB +: 2] : pin_sel;
	assign tk.sel = odf_sel_t'(sel_raw);
	// the phase flop lags a pin change by a cycle, so no filtering forces full current at once
	assign current_full = tk.phase || (tk.sel == ODF_SEL_NONE);
	// trip levels are analog; the choice is handed straight through
	assign industrial_trip = trip_point_select;

	odf_tick_gen #(
		.TICK_CYC_1(TICK_CYC_1),
		.TICK_CYC_2(TICK_CYC_2),
		.TICK_CYC_3(TICK_CYC_3)
	) u_tick (
		.clock(clock),
		.nrst(nrst),
		.tk(tk)
	);

	// ----------------------------------------------------------------
	// glitch filter, one per channel
	// ----------------------------------------------------------------
	wire logic [CH-1:0] filt; // debounced levels
	wire logic bypass; // no filtering selected
	assign bypass = (tk.sel == ODF_SEL_NONE);

	genvar g;
	generate
		for (g = 0; g < CH; g++) begin : gen_ch
			logic [2:0] hist; // last three filter clock samples
			logic level; // debounced level
			wire logic [2:0] next_hist;
			// field input 1 means sensor judged on
			assign next_hist = {hist[1:0], field_inputs[g]};
			assign filt[g] = level;
			// in bypass the filter tracks the input so enabling it is seamless
			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					hist <= 3'h0;
					level <= 1'b0;
				end else if (bypass) begin
					hist <= {3{field_inputs[g]}};
					level <= field_inputs[g];
				end else if (tk.tick) begin
					hist <= next_hist;
					if (next_hist == 3'h7) begin
						level <= 1'b1;
					end else if (next_hist == 3'h0) begin
						level <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// channel n straight to output n; bypass has no flip-flop in the path
	assign channel_logic_outputs = bypass ? field_inputs : filt;

	// ----------------------------------------------------------------
	// fault outputs and events
	// ----------------------------------------------------------------
	logic [CH-1:0] out_q; // last presented outputs
	logic ot_q; // last over-temperature level
	logic uv_q; // last low supply level
	wire logic [`ODF_STS_W-1:0] events; // one-cycle event pulses
	assign events = {supply_low & !uv_q, over_temp & !ot_q, channel_logic_outputs ^ out_q};

	// registered so the pins never glitch on combined terms
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			fault_n <= 1'b1;
			low_supply_alarm_n <= 1'b1;
			out_q <= '0;
			ot_q <= 1'b0;
			uv_q <= 1'b0;
		end else begin
			fault_n <= !(over_temp || supply_low);
			low_supply_alarm_n <= !supply_low;
			out_q <= channel_logic_outputs;
			ot_q <= over_temp;
			uv_q <= supply_low;
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	logic aw_got; // address held
	logic w_got; // data held
	logic [7:0] aw_addr; // held address
	logic [31:0] w_data; // held data
	logic [3:0] w_strb; // held strobes
	wire logic do_write; // both halves present
	wire logic wr_ctrl; // decoded targets
	wire logic wr_status;
	wire logic wr_mask;
	wire logic wr_hit;
	wire logic [31:0] bmask; // byte strobes as a bit mask
	wire logic [`ODF_STS_W-1:0] w1c; // status bits to clear
	wire logic [`ODF_STS_W-1:0] next_status;
	wire logic [`ODF_STS_W-1:0] next_mask;

	assign s_axi_awready = !aw_got && !s_axi_bvalid;
	assign s_axi_wready = !w_got && !s_axi_bvalid;
	assign do_write = aw_got && w_got && !s_axi_bvalid;
	assign wr_ctrl = do_write && (aw_addr == `ODF_OFS_CTRL);
	assign wr_status = do_write && (aw_addr == `ODF_OFS_STATUS);
	assign wr_mask = do_write && (aw_addr == `ODF_OFS_MASK);
	assign wr_hit = wr_ctrl || wr_status || wr_mask || (aw_addr == `ODF_OFS_STATE);
	assign bmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	assign w1c = wr_status ? w_data[`ODF_STS_W-1:0] & bmask[`ODF_STS_W-1:0] : '0;
	// a fresh event beats a clear in the same cycle
	assign next_status = (status & ~w1c) | events;
	assign next_mask = wr_mask ? (mask & ~bmask[`ODF_STS_W-1:0]) |
		(w_data[`ODF_STS_W-1:0] & bmask[`ODF_STS_W-1:0]) : mask;

	// address and data may arrive in either order
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (do_write) begin
				aw_got <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_got <= 1'b0;
			end
		end
	end

	// response and register updates
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ODF_RESP_OKAY;
			ctrl <= `ODF_CTRL_RST;
			status <= '0;
			mask <= '0;
		end else begin
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `ODF_RESP_OKAY : `ODF_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_ctrl) begin
				ctrl <= (ctrl & ~bmask) | (w_data & bmask);
			end
			status <= next_status;
			mask <= next_mask;
		end
	end

	// level interrupt while any unmasked event is pending
	assign irq = |(status & mask);

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	wire logic [31:0] state_word; // live block state
	wire logic [31:0] rd_word; // decoded read value
	wire logic rd_hit;
	assign state_word = {18'h0, trip_point_select, tk.phase, !low_supply_alarm_n,
		!fault_n, sel_raw, channel_logic_outputs};
	assign rd_hit = (s_axi_araddr == `ODF_OFS_CTRL) || (s_axi_araddr == `ODF_OFS_STATUS) ||
		(s_axi_araddr == `ODF_OFS_MASK) || (s_axi_araddr == `ODF_OFS_STATE);
	assign rd_word = (s_axi_araddr == `ODF_OFS_CTRL) ? ctrl :
		(s_axi_araddr == `ODF_OFS_STATUS) ? 32'(status) :
		(s_axi_araddr == `ODF_OFS_MASK) ? 32'(mask) :
		(s_axi_araddr == `ODF_OFS_STATE) ? state_word : 32'h0000_0000;
	assign s_axi_arready = !s_axi_rvalid;

	// one read at a time; data held until taken
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `ODF_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? `ODF_RESP_OKAY : `ODF_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [17:0] gap; // cycles since last filter tick
	logic gap_ok; // a full period measured under one setting
	wire logic [17:0] want_gap; // expected tick spacing
	assign want_gap = (tk.sel == ODF_SEL_SHORT) ? 18'(2 * (TICK_CYC_1 / 2)) :
		(tk.sel == ODF_SEL_MID) ? 18'(2 * (TICK_CYC_2 / 2)) : 18'(2 * (TICK_CYC_3 / 2));
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			gap <= 18'h0_0000;
			gap_ok <= 1'b0;
		end else if (tk.tick) begin
			gap <= 18'h0_0001;
			gap_ok <= 1'b1;
		end else begin
			gap <= gap + 18'h0_0001;
			gap_ok <= gap_ok && !$changed(tk.sel) && !bypass;
		end
	end

	sequence s_three_high;
		gen_ch[0].hist[1:0] == 2'b11 && field_inputs[0] && tk.tick && !bypass;
	endsequence

	bypass_follow_a: assert property (bypass |-> channel_logic_outputs == field_inputs)
		else $error("bypass output does not follow input");
	fault_or_a: assert property (1'b1 |=> fault_n == !($past(over_temp) || $past(supply_low)))
		else $error("common fault not the or of alarms");
	uv_pin_a: assert property ($rose(supply_low) |=> !low_supply_alarm_n)
		else $error("low supply alarm not asserted");
	tick_period_a: assert property (tk.tick && gap_ok |-> gap == want_gap)
		else $error("filter tick spacing wrong");
	stable_rise_a: assert property (s_three_high |=> filt[0])
		else $error("stable level not forwarded");
	no_glitch_a: assert property (!bypass && !$past(bypass) && $rose(filt[0]) |->
		$past(gen_ch[0].hist[1:0]) == 2'b11 && $past(field_inputs[0]))
		else $error("filter forwarded unstable level");
	dc_full_a: assert property (bypass |=> tk.phase && current_full)
		else $error("current switched with no filtering");
	duty_half_a: assert property (tk.half |=> tk.phase != $past(tk.phase))
		else $error("current phase did not toggle");
	set_wins_a: assert property (events[0] && wr_status && w_data[0] && w_strb[0] |=> status[0])
		else $error("event lost under clear");
	irq_level_a: assert property ((|(events & mask)) && !wr_mask |=> irq)
		else $error("unmasked event did not raise interrupt");
endmodule

// File: design/odf_consts.svh
// Notes on behaviour
// - select pins pick none, 25us, 0.75ms, 3ms
// - same select sets current switching period
// - fault low when overtemp or low supply
// - low supply alarm output active low
// - comparator on gives 1, off gives 0
// - trip select 1 industrial, 0 CMOS
// - every channel passes through glitch filter
// - change forwarded after three stable filter cycles
// - filter clock period is third of debounce
// - filter clock toggles current full/fifth, 50% duty
`ifndef ODF_CONSTS_SVH
`define ODF_CONSTS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ODF_CLK_PERIOD_NS 8
`define ODF_DEB1_NS 25000
`define ODF_DEB2_NS 750000
`define ODF_DEB3_NS 3000000
`define ODF_TICK_DIV 3
// filter clock periods in system clock cycles, rounded down
`define ODF_TICK1_CYC ((`ODF_DEB1_NS / `ODF_TICK_DIV) / `ODF_CLK_PERIOD_NS)
`define ODF_TICK2_CYC ((`ODF_DEB2_NS / `ODF_TICK_DIV) / `ODF_CLK_PERIOD_NS)
`define ODF_TICK3_CYC ((`ODF_DEB3_NS / `ODF_TICK_DIV) / `ODF_CLK_PERIOD_NS)
`define ODF_STABLE_SAMPLES 3

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define ODF_OFS_CTRL 8'h00
`define ODF_OFS_STATUS 8'h04
`define ODF_OFS_MASK 8'h08
`define ODF_OFS_STATE 8'h0C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ODF_CTRL_OVR_BIT 0
`define ODF_CTRL_SEL_LSB 1
`define ODF_CTRL_RST 32'h0000_0000
`define ODF_STS_OT_BIT 8
`define ODF_STS_UV_BIT 9
`define ODF_STS_W 10
`define ODF_STATE_SEL_LSB 8
`define ODF_STATE_FAULT_BIT 10
`define ODF_STATE_UV_BIT 11
`define ODF_STATE_PHASE_BIT 12
`define ODF_STATE_TRIP_BIT 13
`define ODF_RESP_OKAY 2'b00
`define ODF_RESP_SLVERR 2'b10

`endif

// File: design/odf_pkg.sv
package odf_pkg;
	// debounce / current switching setting
	typedef enum logic [1:0] {
		ODF_SEL_NONE = 2'b00,
		ODF_SEL_SHORT = 2'b01,
		ODF_SEL_MID = 2'b10,
		ODF_SEL_LONG = 2'b11
	} odf_sel_t;
endpackage

// File: design/odf_tick_if.sv
`timescale 1ns/1ps
interface odf_tick_if;
	import odf_pkg::*;
	odf_sel_t sel; // effective setting
	logic tick; // one pulse per filter clock period
	logic half; // one pulse per half period
	logic phase; // 1 = full current, 0 = one fifth
	modport source(input sel, output tick, output half, output phase);
	modport sink(output sel, input tick, input half, input phase);
endinterface

// File: design/odf_tick_gen.sv
`timescale 1ns/1ps
`include "odf_consts.svh"
module odf_tick_gen import odf_pkg::*; #(
	parameter int TICK_CYC_1 = `ODF_TICK1_CYC,
	parameter int TICK_CYC_2 = `ODF_TICK2_CYC,
	parameter int TICK_CYC_3 = `ODF_TICK3_CYC,
	parameter int CNT_W = 17
) (
	input wire logic clock,
	input wire logic nrst,
	odf_tick_if.source tk
);
	// ----------------------------------------------------------------
	// half period selection
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] cnt; // cycles into current half period
	odf_sel_t sel_q; // setting seen last cycle
	logic phase; // current limit phase
	wire logic [CNT_W-1:0] half_len; // half of the filter clock period
	wire logic running; // filter clock is live and setting is settled
	wire logic half_end; // last cycle of a half period

	// one setting drives both the filter clock and the switching period
	assign half_len = (tk.sel == ODF_SEL_SHORT) ? CNT_W'(TICK_CYC_1 / 2) :
		(tk.sel == ODF_SEL_MID) ? CNT_W'(TICK_CYC_2 / 2) :
		CNT_W'(TICK_CYC_3 / 2);
	assign running = (tk.sel != ODF_SEL_NONE) && (tk.sel == sel_q);
	assign half_end = running && (cnt == half_len - CNT_W'(1));
	assign tk.half = half_end;
	// full period ends as the low half closes
	assign tk.tick = half_end && !phase;
	assign tk.phase = phase;

	// ----------------------------------------------------------------
	// counter and phase
	// ----------------------------------------------------------------
	// a new setting restarts the period so no short half slips out
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt <= '0;
			sel_q <= ODF_SEL_NONE;
			phase <= 1'b1;
		end else begin
			sel_q <= tk.sel;
			if (!running) begin
				cnt <= '0;
				phase <= 1'b1;
			end else if (half_end) begin
				cnt <= '0;
				phase <= !phase;
			end else begin
				cnt <= cnt + CNT_W'(1);
			end
		end
	end
endmodule

// File: dv/odf_mcu_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far side: controller port latch reading the parallel outputs
// ----------------------------------------------------------------
module odf_mcu_model (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [7:0] port_in,
	output logic [7:0] port_latch,
	output logic [15:0] edge_count
);
	// latch every edge like a gpio input register; counting edges lets
	// the bench see a glitch that slipped through even for one cycle
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			port_latch <= 8'h00;
			edge_count <= 16'h0000;
		end else begin
			port_latch <= port_in;
			if (port_latch != port_in) begin
				edge_count <= edge_count + 16'h0001;
			end
		end
	end
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import odf_pkg::*;
	// ----------------------------------------------------------------
	// short filter clock periods, even so half periods are exact
	// ----------------------------------------------------------------
	localparam int TK [4] = '{0, 12, 24, 48};
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] field_inputs = 8'h00;
	logic trip_point_select = 1'b0;
	logic [1:0] sel_pins = 2'b00; // {hi, lo}
	logic over_temp = 1'b0;
	logic supply_low = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire logic [7:0] channel_logic_outputs, port_latch;
	wire logic [15:0] edge_count;
	wire logic fault_n, low_supply_alarm_n, industrial_trip, current_full, irq;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	int fails = 0;
	int total_checks = 0;
	logic [33:0] exp_q [$]; // {resp, data} of reads in flight
	logic [31:0] seed = 32'hcb06_2e3c;
	logic [7:0] pat;
	int n;
	logic [15:0] c0;

	always #4 clock = ~clock;

	odf_top #(.TICK_CYC_1(TK[1]), .TICK_CYC_2(TK[2]), .TICK_CYC_3(TK[3])) dut (
		.clock(clock), .nrst(nrst), .field_inputs(field_inputs),
		.trip_point_select(trip_point_select), .filter_select_lo(sel_pins[0]),
		.filter_select_hi(sel_pins[1]), .over_temp(over_temp), .supply_low(supply_low),
		.channel_logic_outputs(channel_logic_outputs), .fault_n(fault_n),
		.low_supply_alarm_n(low_supply_alarm_n), .industrial_trip(industrial_trip),
		.current_full(current_full), .irq(irq),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
	);

	odf_mcu_model mcu (.clock(clock), .nrst(nrst), .port_in(channel_logic_outputs),
		.port_latch(port_latch), .edge_count(edge_count));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xrand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// write: both halves offered together, each released once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw;
		logic w;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		while (aw || w) begin
			@(posedge clock);
			if (aw && s_axi_awready === 1'b1) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready === 1'b1) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge clock);
		s_axi_bready <= 1'b0;
		check("write resp", 32'(s_axi_bresp), 32'(r));
	endtask

	// read: the expected word is noted, the monitor compares it
	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		exp_q.push_back({r, d});
		do @(posedge clock); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clock); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask

	// read monitor: oldest note is taken whenever a read answer lands
	always @(posedge clock) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("unexpected read", 32'h0000_0001, 32'h0000_0000);
			end else begin
				check("read data", s_axi_rdata, exp_q[0][31:0]);
				check("read resp", 32'(s_axi_rresp), 32'(exp_q[0][33:32]));
				void'(exp_q.pop_front());
			end
		end
	end

	// watchdog, far above the roughly 1500 cycles the run needs
	initial begin
		repeat (60000) @(posedge clock);
		fails++;
		conclude();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		#1;
		check("fault_n", fault_n, 1'b1);
		check("low_supply_alarm_n", low_supply_alarm_n, 1'b1);
		check("current_full", current_full, 1'b1);
		check("irq", irq, 1'b0);
		for (int i = 0; i < 2; i++) begin
			@(posedge clock);
			trip_point_select <= i[0];
			#1;
			check("industrial_trip", industrial_trip, i[0]);
		end
		// bypass: outputs follow the comparators with no clocked delay
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			pat = 8'(xrand());
			field_inputs <= pat;
			#1;
			check("bypass outputs", channel_logic_outputs, pat);
		end
		// each filtered setting: switching period, filter delay, glitch
		for (int s = 1; s < 4; s++) begin
			@(posedge clock);
			sel_pins <= 2'(s);
			field_inputs <= 8'h00;
			repeat (5 * TK[s]) @(posedge clock);
			while (current_full !== 1'b0) @(posedge clock);
			while (current_full !== 1'b1) @(posedge clock);
			n = 0;
			while (current_full === 1'b1) begin
				@(posedge clock);
				n++;
			end
			check("full current half", n, TK[s] / 2);
			n = 0;
			while (current_full === 1'b0) begin
				@(posedge clock);
				n++;
			end
			check("fifth current half", n, TK[s] / 2);
			pat = 8'(xrand()) | 8'h01;
			@(posedge clock);
			field_inputs <= pat;
			n = 0;
			do begin
				@(posedge clock);
				n++;
			end while (channel_logic_outputs !== pat && n < 5 * TK[s]);
			check("filter delay", (n > 2 * TK[s]) && (n <= 3 * TK[s] + 2), 1'b1);
			check("filtered outputs", channel_logic_outputs, pat);
			// a dip of under two filter clocks must never reach the port
			// the port latch counts the last forwarded edge one clock late
			@(posedge clock);
			c0 = edge_count;
			field_inputs <= 8'h00;
			repeat (2 * TK[s] - 1) @(posedge clock);
			field_inputs <= pat;
			repeat (4 * TK[s]) @(posedge clock);
			check("glitch edges", edge_count - c0, 16'h0000);
		end
		// no filtering: current never switches
		@(posedge clock);
		sel_pins <= 2'b00;
		n = 0;
		repeat (100) begin
			@(posedge clock);
			if (current_full !== 1'b1) n++;
		end
		check("current switching off", n, 0);
		// alarms, status, mask and interrupt
		axr(8'h00, 32'h0000_0000, 2'b00);
		axw(8'h04, 32'hffff_ffff, 2'b00);
		axw(8'h08, 32'h0000_0100, 2'b00);
		@(posedge clock);
		supply_low <= 1'b1;
		@(posedge clock);
		#1;
		check("low_supply_alarm_n", low_supply_alarm_n, 1'b0);
		check("fault_n on low supply", fault_n, 1'b0);
		check("irq masked", irq, 1'b0);
		@(posedge clock);
		supply_low <= 1'b0;
		over_temp <= 1'b1;
		@(posedge clock);
		#1;
		check("fault_n on heat", fault_n, 1'b0);
		check("low_supply_alarm_n released", low_supply_alarm_n, 1'b1);
		check("irq raised", irq, 1'b1);
		axr(8'h04, 32'h0000_0300, 2'b00);
		axr(8'h0c, 32'h0000_3400 | {24'h00_0000, pat}, 2'b00);
		axw(8'h04, 32'h0000_0100, 2'b00);
		#1;
		check("irq cleared", irq, 1'b0);
		axr(8'h04, 32'h0000_0200, 2'b00);
		@(posedge clock);
		over_temp <= 1'b0;
		@(posedge clock);
		#1;
		check("fault_n released", fault_n, 1'b1);
		// an output change in the very cycle of a clear must survive it
		fork
			axw(8'h04, 32'h0000_0001, 2'b00);
			begin
				repeat (2) @(posedge clock);
				field_inputs <= field_inputs ^ 8'h01;
			end
		join
		axr(8'h04, 32'h0000_0201, 2'b00);
		// software override of the select pins takes over the setting
		axw(8'h00, 32'h0000_0007, 2'b00);
		axr(8'h0c, 32'h0000_3300 | {24'h00_0000, field_inputs}, 2'b00);
		axw(8'h00, 32'h0000_0000, 2'b00);
		axr(8'h40, 32'h0000_0000, 2'b10);
		axw(8'h40, 32'h0000_0001, 2'b10);
		repeat (2) @(posedge clock);
		conclude();
	end
endmodule
